// [verilog/tav_top.sv]
// Timed average value block: sampler, interval control and registers
// ********************************************************************
// How it works
// RULE_01: Enable rising edge starts period, then outputs mean
// RULE_02: Enable falling edge stops sampling, holds output
// RULE_03: Enable high keeps averaging interval after interval
// RULE_04: Interval end loads output, held until next
// RULE_05: Clear input zeroes output and all accumulators
// RULE_06: Take sample_count samples per period, output mean
// RULE_07: Period unit seconds/minutes/hours/days, ranges clamped
// RULE_08: Seconds: count limited to period times 100
// RULE_09: Hours or days: count limited to 32767
// RULE_10: Minutes: period*6000 up to five, else 32767
// RULE_11: Input scale 0 to 1000, larger values clipped
// RULE_12: Sum divided by count, truncated; samples spaced evenly
// ********************************************************************
`timescale 1ns/1ns
`default_nettype none
module tav_top #(
  parameter int unsigned TICK_CYCLES = tav_pkg::TICK_CYCLES,
  parameter int unsigned AIN_W = tav_pkg::AIN_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic clear_i,
  input wire logic [AIN_W-1:0] analog_in_i,
  input wire logic [tav_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  output logic [AIN_W-1:0] average_out_o,
  output logic sampling_o
);

  // ********************************************************************
  // Helper functions
  // ********************************************************************

  // Base ticks in a whole sampling period; days need all 32 bits
  function automatic logic [31:0] period_ticks(input logic [1:0] unit,
                                               input logic [8:0] period);
    logic [63:0] p;
    p = '0;
    case (unit)
      tav_pkg::UNIT_SEC: p = {23'h0, period} * tav_pkg::TICKS_PER_SEC;
      tav_pkg::UNIT_MIN: p = {23'h0, period} * tav_pkg::TICKS_PER_MIN;
      tav_pkg::UNIT_HOUR: p = {23'h0, period} * tav_pkg::TICKS_PER_HOUR;
      default: p = {23'h0, period} * tav_pkg::TICKS_PER_DAY;
    endcase
    return p[31:0];
  endfunction

  // Largest period value allowed for a unit
  function automatic logic [8:0] period_max(input logic [1:0] unit);
    logic [8:0] m;
    m = tav_pkg::PERIOD_MAX_DAY;
    case (unit)
      tav_pkg::UNIT_SEC: m = tav_pkg::PERIOD_MAX_SEC;
      tav_pkg::UNIT_MIN: m = tav_pkg::PERIOD_MAX_MIN;
      tav_pkg::UNIT_HOUR: m = tav_pkg::PERIOD_MAX_HOUR;
      default: m = tav_pkg::PERIOD_MAX_DAY;
    endcase
    return m;
  endfunction

  // Largest sample count for a unit and period
  function automatic logic [14:0] count_max(input logic [1:0] unit,
                                            input logic [8:0] period);
    logic [29:0] l;
    l = {15'h0, tav_pkg::COUNT_MAX};
    case (unit)
      // RULE_08: seconds count limit
      tav_pkg::UNIT_SEC: l = {6'h0, period} * tav_pkg::COUNT_PER_SEC;
      // RULE_10: minutes count limit
      tav_pkg::UNIT_MIN: begin
        if (period <= tav_pkg::MIN_SHORT_LIMIT) begin
          l = {6'h0, period} * tav_pkg::COUNT_PER_MIN;
        end
      end
      // RULE_09: hours and days limit
      default: l = {15'h0, tav_pkg::COUNT_MAX};
    endcase
    return l[14:0];
  endfunction

  // Clip a value into the range lo..hi
  function automatic logic [14:0] clip(input logic [14:0] v,
                                       input logic [14:0] lo,
                                       input logic [14:0] hi);
    logic [14:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // ********************************************************************
  // Register file
  // ********************************************************************
  typedef enum logic {TAV_IDLE, TAV_RUN} tav_state_t;

  logic [1:0] unit_r;
  logic [1:0] unit_nxt;
  logic [8:0] period_r;
  logic [8:0] period_nxt;
  logic [14:0] count_cfg_r;
  logic [14:0] count_cfg_nxt;
  logic [31:0] rd_data_r;
  logic [31:0] rd_data_nxt;

  tav_state_t state_r;
  tav_state_t state_nxt;
  logic en_prev_r;
  logic en_prev_nxt;
  logic run_r;
  logic run_nxt;
  logic valid_r;
  logic valid_nxt;
  logic [31:0] per_r;
  logic [31:0] per_nxt;
  logic [14:0] count_r;
  logic [14:0] count_nxt;
  logic [31:0] tick_cnt_r;
  logic [31:0] tick_cnt_nxt;
  logic [31:0] acc_r;
  logic [31:0] acc_nxt;
  logic [tav_pkg::SUM_W-1:0] sum_r;
  logic [tav_pkg::SUM_W-1:0] sum_nxt;
  logic [AIN_W-1:0] avg_r;
  logic [AIN_W-1:0] avg_nxt;

  logic tick;
  logic restart;
  logic div_start;
  logic div_done;
  logic [tav_pkg::SUM_W-1:0] div_num;
  logic [tav_pkg::SUM_W-1:0] quotient;

  // Writes clip into the legal ranges, so reads show the values in use
  always_comb begin
    logic [8:0] p_in;
    p_in = wr_data_i[tav_pkg::CFG_PERIOD_LSB +: tav_pkg::PERIOD_W];
    unit_nxt = unit_r;
    period_nxt = period_r;
    count_cfg_nxt = count_cfg_r;
    rd_data_nxt = 32'h0000_0000;
    if (wr_i && addr_i == tav_pkg::REG_CFG) begin
      unit_nxt = wr_data_i[tav_pkg::CFG_UNIT_LSB +: tav_pkg::UNIT_W];
      // RULE_07: clip period range
      period_nxt = 9'(clip({6'h0, p_in}, {6'h0, tav_pkg::PERIOD_MIN},
                           {6'h0, period_max(unit_nxt)}));
    end
    if (wr_i && addr_i == tav_pkg::REG_COUNT) begin
      count_cfg_nxt = wr_data_i[tav_pkg::COUNT_LSB +: tav_pkg::COUNT_W];
    end
    // A new period may shrink the limit, so the count is clipped again
    count_cfg_nxt = clip(count_cfg_nxt, tav_pkg::COUNT_MIN,
                         count_max(unit_nxt, period_nxt));
    if (rd_i) begin
      case (addr_i)
        tav_pkg::REG_CFG: begin
          rd_data_nxt[tav_pkg::CFG_UNIT_LSB +: tav_pkg::UNIT_W] = unit_r;
          rd_data_nxt[tav_pkg::CFG_PERIOD_LSB +: tav_pkg::PERIOD_W] =
            period_r;
        end
        tav_pkg::REG_COUNT: begin
          rd_data_nxt[tav_pkg::COUNT_LSB +: tav_pkg::COUNT_W] = count_cfg_r;
        end
        tav_pkg::REG_STATUS: begin
          rd_data_nxt[tav_pkg::STAT_RUN_BIT] = run_r;
          rd_data_nxt[tav_pkg::STAT_VALID_BIT] = valid_r;
          rd_data_nxt[tav_pkg::STAT_EN_BIT] = en_prev_r;
        end
        tav_pkg::REG_AVG: begin
          rd_data_nxt[AIN_W-1:0] = avg_r;
        end
        default: rd_data_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      unit_r <= tav_pkg::RST_UNIT;
      period_r <= tav_pkg::RST_PERIOD;
      count_cfg_r <= tav_pkg::RST_COUNT;
      rd_data_r <= 32'h0000_0000;
    end else if (ce_i) begin
      unit_r <= unit_nxt;
      period_r <= period_nxt;
      count_cfg_r <= count_cfg_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // ********************************************************************
  // Interval control and accumulation
  // ********************************************************************

  // Period and count are latched per interval; config edits apply later
  always_comb begin
    logic [31:0] acc_sum;
    logic [tav_pkg::SUM_W-1:0] sum_add;
    logic [AIN_W-1:0] sample;
    logic take;
    logic rise;
    acc_sum = acc_r + {17'h0, count_r};
    take = (acc_sum >= per_r);
    // RULE_11: clip input to full scale
    sample = (analog_in_i > AIN_W'(tav_pkg::AIN_FULL)) ?
             AIN_W'(tav_pkg::AIN_FULL) : analog_in_i;
    sum_add = take ? sum_r + tav_pkg::SUM_W'(sample) : sum_r;
    rise = enable_i & ~en_prev_r;
    state_nxt = state_r;
    en_prev_nxt = enable_i;
    valid_nxt = valid_r;
    per_nxt = per_r;
    count_nxt = count_r;
    tick_cnt_nxt = tick_cnt_r;
    acc_nxt = acc_r;
    sum_nxt = sum_r;
    avg_nxt = avg_r;
    restart = 1'b0;
    div_start = 1'b0;
    div_num = sum_add;
    if (clear_i) begin
      // RULE_05: clear output, accumulators, tick count and valid to zero
      tick_cnt_nxt = '0;
      acc_nxt = '0;
      sum_nxt = '0;
      avg_nxt = '0;
      valid_nxt = 1'b0;
      restart = 1'b1;
    end else begin
      case (state_r)
        TAV_IDLE: begin
          // RULE_01: rising edge opens a period
          if (rise) begin
            state_nxt = TAV_RUN;
            per_nxt = period_ticks(unit_r, period_r);
            count_nxt = count_cfg_r;
            tick_cnt_nxt = '0;
            acc_nxt = '0;
            sum_nxt = '0;
            restart = 1'b1;
          end
        end
        TAV_RUN: begin
          if (!enable_i) begin
            // RULE_02: stop, partial interval dropped
            state_nxt = TAV_IDLE;
          end else if (tick) begin
            // RULE_12: even spacing by error accumulator
            acc_nxt = take ? acc_sum - per_r : acc_sum;
            // RULE_06: count samples across the period
            if (32'(tick_cnt_r + 32'h1) == per_r) begin
              // RULE_03: next interval starts at once
              div_start = 1'b1;
              per_nxt = period_ticks(unit_r, period_r);
              count_nxt = count_cfg_r;
              tick_cnt_nxt = '0;
              acc_nxt = '0;
              sum_nxt = '0;
            end else begin
              tick_cnt_nxt = 32'(tick_cnt_r + 32'h1);
              sum_nxt = sum_add;
            end
          end
        end
        default: state_nxt = TAV_IDLE;
      endcase
      // RULE_04: load mean at interval end
      if (div_done) begin
        avg_nxt = quotient[AIN_W-1:0];
        valid_nxt = 1'b1;
      end
    end
    run_nxt = (state_nxt == TAV_RUN);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= TAV_IDLE;
      en_prev_r <= 1'b0;
      run_r <= 1'b0;
      valid_r <= 1'b0;
      per_r <= 32'h0000_0000;
      count_r <= tav_pkg::RST_COUNT;
      tick_cnt_r <= 32'h0000_0000;
      acc_r <= 32'h0000_0000;
      sum_r <= '0;
      avg_r <= '0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      en_prev_r <= en_prev_nxt;
      run_r <= run_nxt;
      valid_r <= valid_nxt;
      per_r <= per_nxt;
      count_r <= count_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      acc_r <= acc_nxt;
      sum_r <= sum_nxt;
      avg_r <= avg_nxt;
    end
  end

  // ********************************************************************
  // Time base and divider
  // ********************************************************************

  // Base tick, realigned when enable opens a period and on clear
  tav_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .restart_i(restart),
    .tick_o(tick)
  );

  // RULE_12: truncating division by count
  tav_div #(
    .NUM_W(tav_pkg::SUM_W),
    .DEN_W(tav_pkg::COUNT_W)
  ) u_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(div_start),
    .abort_i(clear_i),
    .dividend_i(div_num),
    .divisor_i(count_r),
    .done_o(div_done),
    .quotient_o(quotient)
  );

  // Outputs straight from flip-flops
  assign rd_data_o = rd_data_r;
  assign average_out_o = avg_r;
  assign sampling_o = run_r;

endmodule
`default_nettype wire

// [inc/tav_pkg.sv]
// Constants shared by the timed average value block
`default_nettype none
package tav_pkg;

  // ********************************************************************
  // Clock and time base
  // ********************************************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned HZ_PER_MHZ = 1_000_000;
  // Base tick of 10 ms: the finest spacing of samples ever needed
  localparam int unsigned TICK_US = 10_000;
  localparam int unsigned TICK_CYCLES = TICK_US * (CLK_HZ / HZ_PER_MHZ);

  // Base ticks in one unit of the sampling period
  localparam logic [31:0] TICKS_PER_SEC = 32'h0000_0064;
  localparam logic [31:0] TICKS_PER_MIN = 32'h0000_1770;
  localparam logic [31:0] TICKS_PER_HOUR = 32'h0005_7E40;
  localparam logic [31:0] TICKS_PER_DAY = 32'h0083_D600;

  // ********************************************************************
  // Sampling period and sample count ranges
  // ********************************************************************
  localparam int unsigned UNIT_W = 2;
  localparam logic [1:0] UNIT_SEC = 2'h0;
  localparam logic [1:0] UNIT_MIN = 2'h1;
  localparam logic [1:0] UNIT_HOUR = 2'h2;
  localparam logic [1:0] UNIT_DAY = 2'h3;

  localparam int unsigned PERIOD_W = 9;
  localparam logic [8:0] PERIOD_MIN = 9'h001;
  localparam logic [8:0] PERIOD_MAX_SEC = 9'h03B;
  localparam logic [8:0] PERIOD_MAX_MIN = 9'h03B;
  localparam logic [8:0] PERIOD_MAX_HOUR = 9'h017;
  localparam logic [8:0] PERIOD_MAX_DAY = 9'h16D;

  localparam int unsigned COUNT_W = 15;
  localparam logic [14:0] COUNT_MIN = 15'h0001;
  localparam logic [14:0] COUNT_MAX = 15'h7FFF;
  localparam logic [14:0] COUNT_PER_SEC = 15'h0064;
  localparam logic [14:0] COUNT_PER_MIN = 15'h1770;
  localparam logic [8:0] MIN_SHORT_LIMIT = 9'h005;

  // ********************************************************************
  // Analogue scale and arithmetic widths
  // ********************************************************************
  localparam int unsigned AIN_W = 10;
  localparam logic [9:0] AIN_FULL = 10'h3E8;
  localparam int unsigned SUM_W = 32;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_COUNT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_AVG = 8'h0C;

  localparam int unsigned CFG_PERIOD_LSB = 0;
  localparam int unsigned CFG_UNIT_LSB = 12;
  localparam int unsigned COUNT_LSB = 0;
  localparam int unsigned STAT_RUN_BIT = 0;
  localparam int unsigned STAT_VALID_BIT = 1;
  localparam int unsigned STAT_EN_BIT = 2;

  localparam logic [1:0] RST_UNIT = UNIT_SEC;
  localparam logic [8:0] RST_PERIOD = 9'h001;
  localparam logic [14:0] RST_COUNT = 15'h0001;

endpackage
`default_nettype wire

// [verilog/tav_tick.sv]
// Base tick generator for the timed average value block
`timescale 1ns/1ns
`default_nettype none
module tav_tick #(
  parameter int unsigned CYCLES = tav_pkg::TICK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic restart_i,
  output logic tick_o
);

  localparam int unsigned CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // Restart realigns the ticks so a period is whole base ticks long
  always_comb begin
    cnt_nxt = cnt_r + CNT_W'(1);
    tick_nxt = 1'b0;
    if (restart_i) begin
      cnt_nxt = '0;
    end else if (cnt_r == LAST) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule
`default_nettype wire

// [verilog/tav_div.sv]
// Sequential restoring divider for the interval mean
`timescale 1ns/1ns
`default_nettype none
module tav_div #(
  parameter int unsigned NUM_W = tav_pkg::SUM_W,
  parameter int unsigned DEN_W = tav_pkg::COUNT_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [NUM_W-1:0] dividend_i,
  input wire logic [DEN_W-1:0] divisor_i,
  output logic done_o,
  output logic [NUM_W-1:0] quotient_o
);

  localparam int unsigned CNT_W = $clog2(NUM_W + 1);

  logic [DEN_W:0] rem_r;
  logic [DEN_W:0] rem_nxt;
  logic [NUM_W-1:0] quo_r;
  logic [NUM_W-1:0] quo_nxt;
  logic [DEN_W-1:0] den_r;
  logic [DEN_W-1:0] den_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic done_r;
  logic done_nxt;
  logic [DEN_W:0] shifted;

  // One quotient bit per cycle; quotient truncates toward zero
  always_comb begin
    rem_nxt = rem_r;
    quo_nxt = quo_r;
    den_nxt = den_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    shifted = {rem_r[DEN_W-1:0], quo_r[NUM_W-1]};
    if (abort_i) begin
      cnt_nxt = '0;
    end else if (start_i) begin
      rem_nxt = '0;
      quo_nxt = dividend_i;
      den_nxt = divisor_i;
      cnt_nxt = CNT_W'(NUM_W);
    end else if (cnt_r != '0) begin
      if (shifted >= {1'b0, den_r}) begin
        rem_nxt = shifted - {1'b0, den_r};
        quo_nxt = {quo_r[NUM_W-2:0], 1'b1};
      end else begin
        rem_nxt = shifted;
        quo_nxt = {quo_r[NUM_W-2:0], 1'b0};
      end
      cnt_nxt = cnt_r - CNT_W'(1);
      done_nxt = (cnt_r == CNT_W'(1));
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rem_r <= '0;
      quo_r <= '0;
      den_r <= '0;
      cnt_r <= '0;
      done_r <= 1'b0;
    end else if (ce_i) begin
      rem_r <= rem_nxt;
      quo_r <= quo_nxt;
      den_r <= den_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;
  assign quotient_o = quo_r;

endmodule
`default_nettype wire

// [test/tav_asserts.sv]
// Port-level concurrent checks for the timed average value block
`timescale 1ns/1ns
`default_nettype none
module tav_asserts #(
  parameter int unsigned TICK_CYCLES = 40,
  parameter int unsigned AIN_W = 10
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic clear_i,
  input wire logic [AIN_W-1:0] analog_in_i,
  input wire logic [tav_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rd_data_o,
  input wire logic [AIN_W-1:0] average_out_o,
  input wire logic sampling_o
);
  // ******************************************************************
  // Helper logic
  // ******************************************************************
  logic [7:0] idle_r;
  logic [7:0] idle_nxt;
  logic mapped;

  // Enabled cycles since sampling stopped; a stalled clock enable delays
  // the divider, so only cycles that move the design are counted
  always_comb begin
    idle_nxt = idle_r;
    if (sampling_o) begin
      idle_nxt = 8'h00;
    end else if (idle_r != 8'hFF) begin
      idle_nxt = idle_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      idle_r <= 8'h00;
    end else if (ce_i) begin
      idle_r <= idle_nxt;
    end
  end

  // Address decode of the four registers
  assign mapped = addr_i == tav_pkg::REG_CFG || addr_i == tav_pkg::REG_COUNT
    || addr_i == tav_pkg::REG_STATUS || addr_i == tav_pkg::REG_AVG;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  a_rd_data_idle: assert property (
    ce_i && !rd_i |=> rd_data_o == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_avg_in_range: assert property (
    average_out_o <= AIN_W'(1000))
    else $error("average above full scale");
  a_clear_zeroes: assert property (
    ce_i && clear_i |=> average_out_o == '0)
    else $error("average not zero during clear");
  a_avg_read_back: assert property (
    ce_i && rd_i && addr_i == tav_pkg::REG_AVG
    |=> rd_data_o == 32'($past(average_out_o)))
    else $error("average register differs from output");
  a_status_run_bit: assert property (
    ce_i && rd_i && addr_i == tav_pkg::REG_STATUS
    |=> rd_data_o[tav_pkg::STAT_RUN_BIT] == $past(sampling_o))
    else $error("status running bit wrong");
  a_unmapped_zero: assert property (
    ce_i && rd_i && !mapped |=> rd_data_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_enable_stop: assert property (
    ce_i && $fell(enable_i) |-> ##[1:2] !sampling_o)
    else $error("sampling kept after enable fell");
  a_enable_start: assert property (
    ce_i && $rose(enable_i) && !clear_i && !sampling_o
    |-> ##[1:2] sampling_o)
    else $error("sampling not started on enable");
  a_idle_hold: assert property (
    idle_r > 8'h3C && !clear_i && !$past(clear_i)
    |-> $stable(average_out_o))
    else $error("average changed while stopped");
  a_ce_freeze: assert property (
    !ce_i |=> $stable(average_out_o) && $stable(sampling_o)
    && $stable(rd_data_o))
    else $error("outputs moved while clock enable low");

  c_avg_update: cover property (sampling_o && $changed(average_out_o));
  c_clear_hit: cover property (clear_i && sampling_o);
  c_unmapped: cover property (rd_i && !mapped);
endmodule

bind tav_top tav_asserts #(
  .TICK_CYCLES(TICK_CYCLES),
  .AIN_W(AIN_W)
) asserts_u (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .enable_i(enable_i),
  .clear_i(clear_i), .analog_in_i(analog_in_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .average_out_o(average_out_o), .sampling_o(sampling_o)
);
`default_nettype wire

// [test/tb.sv]
// Self-checking testbench for the timed average value block
`timescale 1ns/1ns
`default_nettype none
module tb;
  // Short base tick keeps a one-second interval at 4000 cycles
  localparam int unsigned TCYC = 40;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic enable_i = 1'b0;
  logic clear_i = 1'b0;
  logic [9:0] analog_in_i = 10'h000;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rd_data_o;
  logic [9:0] average_out_o;
  logic sampling_o;
  int error_cnt = 0;
  int compares = 0;
  logic [9:0] va, vb, vc, mean;
  logic [1:0] u;
  logic [8:0] p, pc;
  logic [14:0] c;

  always begin
    #50 clk_sys_i = ~clk_sys_i;
  end

  tav_top #(.TICK_CYCLES(TCYC)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .enable_i(enable_i),
    .clear_i(clear_i), .analog_in_i(analog_in_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .average_out_o(average_out_o), .sampling_o(sampling_o)
  );

  // ******************************************************************
  // Expectation helpers
  // ******************************************************************
  function automatic logic [8:0] pclip(input logic [1:0] un,
                                       input logic [8:0] pe);
    logic [8:0] mx;
    mx = (un == 2'h3) ? 9'h16D : (un == 2'h2) ? 9'h017 : 9'h03B;
    pclip = (pe == 9'h000) ? 9'h001 : (pe > mx) ? mx : pe;
  endfunction

  function automatic logic [14:0] cclip(input logic [1:0] un,
                                        input logic [8:0] pe,
                                        input logic [14:0] cn);
    logic [14:0] lim;
    lim = 15'h7FFF;
    if (un == 2'h0) begin
      lim = 15'(int'(pe) * 100);
    end else if (un == 2'h1 && pe <= 9'h005) begin
      lim = 15'(int'(pe) * 6000);
    end
    cclip = (cn == 15'h0000) ? 15'h0001 : (cn > lim) ? lim : cn;
  endfunction

  // ******************************************************************
  // Bus and compare tasks
  // ******************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe, so look mid-cycle
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(rd_data_o, exp);
  endtask

  // Bounded wait for an interval result; a miss counts as a mismatch
  task automatic wait_avg(input logic [9:0] e);
    int n;
    n = 0;
    while (average_out_o !== e && n < 5000) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(32'(average_out_o), 32'(e));
  endtask

  task automatic stop_test();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ******************************************************************
  // Test sequence
  // ******************************************************************
  initial begin
    void'($urandom(17200));
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd_reg(tav_pkg::REG_CFG, 32'h0000_0001);
    rd_reg(tav_pkg::REG_COUNT, 32'h0000_0001);
    rd_reg(tav_pkg::REG_STATUS, 32'h0000_0000);
    rd_reg(tav_pkg::REG_AVG, 32'h0000_0000);
    rd_reg(8'h10, 32'h0000_0000);
    // Minute corners first, then random units, periods and counts
    for (int i = 0; i < 12; i++) begin
      u = 2'($urandom_range(3));
      p = 9'($urandom_range(511));
      c = 15'($urandom_range(32767));
      if (i < 3) begin
        u = tav_pkg::UNIT_MIN;
        p = 9'h005 + 9'(i);
        c = (i == 2) ? 15'h0000 : 15'h7FFF;
      end
      pc = pclip(u, p);
      wr_reg(tav_pkg::REG_CFG, (32'(u) << 12) | 32'(p));
      wr_reg(tav_pkg::REG_COUNT, 32'(c));
      rd_reg(tav_pkg::REG_CFG, (32'(u) << 12) | 32'(pc));
      rd_reg(tav_pkg::REG_COUNT, 32'(cclip(u, pc, c)));
    end
    // Two samples per second; input changes between them
    wr_reg(tav_pkg::REG_CFG, 32'h0000_0001);
    wr_reg(tav_pkg::REG_COUNT, 32'h0000_0002);
    // Nonzero inputs so the first result differs from the reset value
    va = 10'($urandom_range(900, 100));
    vb = 10'($urandom_range(900, 100));
    vc = 10'($urandom_range(900, 100));
    mean = 10'((int'(va) + int'(vb)) / 2);
    @(posedge clk_sys_i);
    analog_in_i <= va;
    enable_i <= 1'b1;
    repeat (3000) @(posedge clk_sys_i);
    analog_in_i <= vb;
    wait_avg(mean);
    // Over-range input must clip to full scale
    @(posedge clk_sys_i);
    analog_in_i <= 10'h3FF;
    repeat (1000) @(posedge clk_sys_i);
    // Clock enable low stalls the interval; the result only comes later
    ce_i <= 1'b0;
    repeat (50) @(posedge clk_sys_i);
    ce_i <= 1'b1;
    repeat (950) @(posedge clk_sys_i);
    chk(32'(average_out_o), 32'(mean));
    chk(32'(sampling_o), 32'h0000_0001);
    wait_avg(10'h3E8);
    rd_reg(tav_pkg::REG_AVG, 32'h0000_03E8);
    rd_reg(tav_pkg::REG_STATUS, 32'h0000_0007);
    // Drop enable mid-interval: partial interval is discarded
    @(posedge clk_sys_i);
    analog_in_i <= vc;
    repeat (1500) @(posedge clk_sys_i);
    enable_i <= 1'b0;
    repeat (4500) @(posedge clk_sys_i);
    chk(32'(sampling_o), 32'h0000_0000);
    chk(32'(average_out_o), 32'h0000_03E8);
    enable_i <= 1'b1;
    wait_avg(vc);
    // Clear zeroes the output and the register view
    @(posedge clk_sys_i);
    clear_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk(32'(average_out_o), 32'h0000_0000);
    rd_reg(tav_pkg::REG_AVG, 32'h0000_0000);
    @(posedge clk_sys_i);
    clear_i <= 1'b0;
    enable_i <= 1'b0;
    repeat (100) @(posedge clk_sys_i);
    chk(32'(average_out_o), 32'h0000_0000);
    stop_test();
  end

  // Watchdog: the full sequence needs about 18400 cycles
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
